// ===== logic/spl_map.svh
// Purpose: Offsets, field positions, reset values and timing figures of the port lock block.
// Assumes: Register addresses are 16 bits wide and registers are 8 bits wide.
// Notes: Definitions only; included by the design modules, not by the package.
`ifndef SPL_MAP_SVH
`define SPL_MAP_SVH

// Register addresses.
`define SPL_ADDR_LPO_LEVEL 16'hec00
`define SPL_ADDR_REF_PORT_CFG 16'hec01

// Reset values.
`define SPL_RST_LPO_LEVEL 8'h07
`define SPL_RST_REF_PORT_CFG 8'h00

// Field positions in the low-power overcurrent level register.
`define SPL_THR_LSB 0
`define SPL_THR_MSB 2
`define SPL_LINE_LSB 3
`define SPL_LINE_MSB 7

// Field positions in the reference and port configuration register.
`define SPL_EXTREF_BIT 0
`define SPL_LOCK_BIT 1

// The threshold is full scale times the field over eight, a shift by three.
`define SPL_THR_SHIFT 3

// Number of slave-select toggles that switches the host port to SPI.
`define SPL_SS_TOGGLES 3

// One line period is a fiftieth of a second, given here in microseconds.
`define SPL_LINE_PERIOD_US 20000
`define SPL_CLK_PERIOD_NS 10

`endif

// ===== logic/spl_pkg.sv
// Purpose: Types shared by the port lock block.
// Assumes: Field layouts follow spl_map.svh.
// Notes: Struct layouts mirror the register bit order, msb first.
package spl_pkg;

  // Phase voltage used as time base for the harmonic calculations.
  typedef enum logic [1:0] {
    SPL_PH_A,
    SPL_PH_B,
    SPL_PH_C
  } spl_phase_t;

  // Active host serial port.
  typedef enum logic {
    SPL_PORT_I2C,
    SPL_PORT_SPI
  } spl_port_t;

  // Low-power overcurrent level register layout.
  typedef struct packed {
    logic [4:0] line_count;
    logic [2:0] threshold;
  } spl_lpo_level_t;

  // Reference and port configuration register layout.
  typedef struct packed {
    logic [5:0] reserved;
    logic port_lock;
    logic ext_ref;
  } spl_ref_port_cfg_t;

  // Register access request from the serial-port front end.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } spl_reg_req_t;

endpackage

// ===== logic/spl_port_select.sv
// Purpose: Chooses between the I2C and SPI host ports and holds the port lock.
// Assumes: ss_level is already synchronised to clk.
// Notes: The lock clears only on reset, so power-mode changes keep the choice.
`timescale 1ns/1ps
`include "spl_map.svh"
module spl_port_select
  import spl_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Synchronised slave-select level and configuration write.
  input wire logic ss_level,
  input wire logic cfg_wr,
  input wire logic cfg_lock_bit,
  // Port state.
  output spl_port_t port_reg,
  output logic locked_reg
);

  spl_port_t port_next; // Next active port.
  logic locked_next; // Next lock state.
  logic ss_prev_reg; // Previous slave-select level, for edge detection.
  logic [1:0] toggle_cnt_reg; // Falling edges seen so far.
  logic [1:0] toggle_cnt_next;
  logic ss_fall; // One-cycle falling edge of the slave-select pin.

  assign ss_fall = ss_prev_reg && !ss_level;

  // Next-state logic for port choice, toggle count and lock.
  always_comb begin
    port_next = port_reg;
    locked_next = locked_reg;
    toggle_cnt_next = toggle_cnt_reg;
    case (port_reg)
      SPL_PORT_I2C: begin
        // Toggles count only while unlocked; a locked I2C port ignores the pin.
        if (!locked_reg && ss_fall) begin
          if (toggle_cnt_reg == 2'(`SPL_SS_TOGGLES - 1)) begin
            port_next = SPL_PORT_SPI;
          end else begin
            toggle_cnt_next = toggle_cnt_reg + 2'h1;
          end
        end
        // The host locks the I2C port by writing the lock bit as one.
        if (cfg_wr && cfg_lock_bit) begin
          locked_next = 1'b1;
        end
      end
      SPL_PORT_SPI: begin
        // Any configuration write over SPI locks the port, whatever the data.
        if (cfg_wr) begin
          locked_next = 1'b1;
        end
      end
      default: begin
        port_next = SPL_PORT_I2C;
      end
    endcase
  end

  // State registers; nothing but reset can unlock the port.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_reg <= SPL_PORT_I2C;
      locked_reg <= 1'b0;
      toggle_cnt_reg <= 2'h0;
      ss_prev_reg <= 1'b1;
    end else begin
      port_reg <= port_next;
      locked_reg <= locked_next;
      toggle_cnt_reg <= toggle_cnt_next;
      ss_prev_reg <= ss_level;
    end
  end

  // Third falling edge while unlocked on I2C switches to SPI.
  sequence s_third_toggle;
    !locked_reg && port_reg == SPL_PORT_I2C && ss_fall && toggle_cnt_reg == 2'h2;
  endsequence
  property p_three_toggles;
    @(posedge clk) disable iff (!rst_n)
      s_third_toggle |=> port_reg == SPL_PORT_SPI;
  endproperty
  a_three_toggles: assert property (p_three_toggles) else $error("SPI not selected.");

  // A locked I2C port never moves to SPI.
  property p_i2c_stays;
    @(posedge clk) disable iff (!rst_n)
      locked_reg && port_reg == SPL_PORT_I2C |=> port_reg == SPL_PORT_I2C;
  endproperty
  a_i2c_stays: assert property (p_i2c_stays) else $error("Locked I2C left.");

  // Lock write on I2C takes effect on the next edge.
  property p_i2c_lock;
    @(posedge clk) disable iff (!rst_n)
      port_reg == SPL_PORT_I2C && cfg_wr && cfg_lock_bit |=> locked_reg;
  endproperty
  a_i2c_lock: assert property (p_i2c_lock) else $error("I2C lock missed.");

  // Any write while on SPI locks.
  property p_spi_lock;
    @(posedge clk) disable iff (!rst_n)
      port_reg == SPL_PORT_SPI && cfg_wr |=> locked_reg ##1 locked_reg;
  endproperty
  a_spi_lock: assert property (p_spi_lock) else $error("SPI lock missed.");

  // Once locked, the port choice holds still.
  property p_port_held;
    @(posedge clk) disable iff (!rst_n)
      locked_reg |=> $stable(port_reg);
  endproperty
  a_port_held: assert property (p_port_held) else $error("Locked port changed.");

  // The lock never clears outside reset.
  property p_lock_sticky;
    @(posedge clk) disable iff (!rst_n)
      locked_reg |=> locked_reg;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("Lock cleared.");

endmodule

// ===== logic/spl_config.sv
// Purpose: Low-power overcurrent and reference/port configuration registers.
// Assumes: Register requests come from the active serial-port front end on clk.
// Notes: The slave-select pin is asynchronous and passes two flip-flops first.
//
// Overview of operation
// - Time base code 00 selects phase A.
// - Codes 01 B, 10 C, 11 also C.
// - Threshold is full scale times field/8.
// - Measurement period is (line count+1)/50 seconds.
// - Reference bit 0 internal, 1 external.
// - Three slave-select toggles unlocked switch to SPI.
// - I2C locked by bit; toggles then ignored.
// - Any write to the reference/port register over SPI locks the port.
// - Locked port survives power mode changes.
`timescale 1ns/1ps
`include "spl_map.svh"
module spl_config
  import spl_pkg::*;
#(
  parameter int FS_W = 24,
  parameter logic [FS_W-1:0] FULL_SCALE = 24'hff_ffff,
  parameter int LINE_PERIOD_CYCLES = `SPL_LINE_PERIOD_US * 1000 / `SPL_CLK_PERIOD_NS
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register access from the serial-port front end.
  input wire spl_reg_req_t req,
  output logic [7:0] rdata_reg,
  output logic rvalid_reg,
  // Host-port pins and state.
  input wire logic slave_select_pin,
  input wire logic [1:0] power_modes,
  output spl_port_t port_reg,
  output logic port_locked_reg,
  // Harmonic time base selection.
  input wire logic [1:0] harmonic_timebase_phase_sel,
  output spl_phase_t timebase_phase_reg,
  // Overcurrent and reference outputs.
  output logic [FS_W-1:0] lp_threshold_reg,
  output logic lp_period_tick_reg,
  output logic external_reference_select_reg
);

  spl_lpo_level_t lpo_reg; // Low-power overcurrent level register.
  spl_lpo_level_t lpo_next;
  logic ext_ref_next; // Next reference select.
  logic [7:0] rdata_next;
  logic rvalid_next;
  spl_phase_t phase_next;
  logic [FS_W-1:0] thr_next;
  logic [FS_W+2:0] thr_prod; // Full scale times field, before the divide.
  logic [31:0] cyc_cnt_reg; // Cycles within one line period.
  logic [31:0] cyc_cnt_next;
  logic [4:0] line_cnt_reg; // Completed line periods in this measurement.
  logic [4:0] line_cnt_next;
  logic tick_next;
  logic ss_meta_reg; // First synchroniser stage; read only by ss_sync_reg.
  logic ss_sync_reg; // Second synchroniser stage.
  logic lpo_wr; // Write strobe for the overcurrent level register.
  logic cfg_wr; // Write strobe for the reference and port register.

  // Maps the time base code onto a phase; the reserved code falls to C.
  function automatic spl_phase_t decode_phase(input logic [1:0] code);
    case (code)
      2'h0: decode_phase = SPL_PH_A;
      2'h1: decode_phase = SPL_PH_B;
      default: decode_phase = SPL_PH_C;
    endcase
  endfunction

  assign lpo_wr = req.wr && req.addr == `SPL_ADDR_LPO_LEVEL;
  assign cfg_wr = req.wr && req.addr == `SPL_ADDR_REF_PORT_CFG;

  // Power-mode changes do not reach the port selector at all, so they cannot disturb it.
  spl_port_select u_sel (
    .clk(clk),
    .rst_n(rst_n),
    .ss_level(ss_sync_reg),
    .cfg_wr(cfg_wr),
    .cfg_lock_bit(req.wdata[`SPL_LOCK_BIT]),
    .port_reg(port_reg),
    .locked_reg(port_locked_reg)
  );

  // Register writes and reads; unmapped reads answer zero.
  always_comb begin
    lpo_next = lpo_reg;
    ext_ref_next = external_reference_select_reg;
    rdata_next = 8'h00;
    rvalid_next = req.rd;
    if (lpo_wr) begin
      lpo_next = req.wdata;
    end
    if (cfg_wr) begin
      ext_ref_next = req.wdata[`SPL_EXTREF_BIT];
    end
    if (req.rd) begin
      case (req.addr)
        `SPL_ADDR_LPO_LEVEL: rdata_next = lpo_reg;
        `SPL_ADDR_REF_PORT_CFG: begin
          // The lock bit reads back the lock state, not the last written value.
          rdata_next = {6'h00, port_locked_reg, external_reference_select_reg};
        end
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Threshold and time base; a multiply then a shift avoids losing low bits.
  always_comb begin
    thr_prod = (FS_W+3)'(FULL_SCALE) * (FS_W+3)'(lpo_reg.threshold);
    thr_next = thr_prod[FS_W+2:`SPL_THR_SHIFT];
    phase_next = decode_phase(harmonic_timebase_phase_sel);
  end

  // Measurement period: line count plus one periods of a fiftieth of a second.
  always_comb begin
    cyc_cnt_next = cyc_cnt_reg + 32'h1;
    line_cnt_next = line_cnt_reg;
    tick_next = 1'b0;
    if (cyc_cnt_reg == 32'(LINE_PERIOD_CYCLES - 1)) begin
      cyc_cnt_next = 32'h0;
      if (line_cnt_reg >= lpo_reg.line_count) begin
        line_cnt_next = 5'h0;
        tick_next = 1'b1;
      end else begin
        line_cnt_next = line_cnt_reg + 5'h1;
      end
    end
  end

  // All state registers of the block outside the port selector.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lpo_reg <= `SPL_RST_LPO_LEVEL;
      external_reference_select_reg <= 1'b0;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      lp_threshold_reg <= '0;
      timebase_phase_reg <= SPL_PH_A;
      cyc_cnt_reg <= 32'h0;
      line_cnt_reg <= 5'h0;
      lp_period_tick_reg <= 1'b0;
      ss_meta_reg <= 1'b1;
      ss_sync_reg <= 1'b1;
    end else begin
      lpo_reg <= lpo_next;
      external_reference_select_reg <= ext_ref_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      lp_threshold_reg <= thr_next;
      timebase_phase_reg <= phase_next;
      cyc_cnt_reg <= cyc_cnt_next;
      line_cnt_reg <= line_cnt_next;
      lp_period_tick_reg <= tick_next;
      ss_meta_reg <= slave_select_pin;
      ss_sync_reg <= ss_meta_reg;
    end
  end

  // Code 00 gives phase A one edge later.
  property p_phase_a;
    @(posedge clk) disable iff (!rst_n)
      harmonic_timebase_phase_sel == 2'h0 |=> timebase_phase_reg == SPL_PH_A;
  endproperty
  a_phase_a: assert property (p_phase_a) else $error("Phase A not chosen.");

  // Codes 10 and 11 both give phase C; 01 gives B.
  property p_phase_bc;
    @(posedge clk) disable iff (!rst_n)
      harmonic_timebase_phase_sel != 2'h0 |=> timebase_phase_reg ==
        ($past(harmonic_timebase_phase_sel) == 2'h1 ? SPL_PH_B : SPL_PH_C);
  endproperty
  a_phase_bc: assert property (p_phase_bc) else $error("Phase B or C wrong.");

  // Threshold follows the field two edges after a write.
  sequence s_lpo_write;
    lpo_wr ##1 !lpo_wr;
  endsequence
  property p_threshold;
    @(posedge clk) disable iff (!rst_n)
      s_lpo_write |=> lp_threshold_reg ==
        FS_W'(((FS_W+3)'(FULL_SCALE) * (FS_W+3)'($past(req.wdata[2:0], 2))) >> 3);
  endproperty
  a_threshold: assert property (p_threshold) else $error("Threshold wrong.");

  // A tick is seen only together with both counters wrapped back to zero.
  property p_period;
    @(posedge clk) disable iff (!rst_n)
      lp_period_tick_reg |-> cyc_cnt_reg == 32'h0 && line_cnt_reg == 5'h0;
  endproperty
  a_period: assert property (p_period) else $error("Period tick early.");

  // A power-mode change while locked leaves the port where it was.
  property p_modes_kept;
    @(posedge clk) disable iff (!rst_n)
      port_locked_reg && $changed(power_modes) |=> $stable(port_reg);
  endproperty
  a_modes_kept: assert property (p_modes_kept) else $error("Port moved on mode change.");

  // Reference select follows bit 0 of a configuration write.
  property p_ext_ref;
    @(posedge clk) disable iff (!rst_n)
      cfg_wr |=> external_reference_select_reg == $past(req.wdata[0]);
  endproperty
  a_ext_ref: assert property (p_ext_ref) else $error("Reference select wrong.");

endmodule

// ===== test/spl_host_model.sv
// Purpose: Host microcontroller model that drives register requests and the slave-select pin.
// Assumes: The block samples its inputs on the rising edge of clk.
// Notes: Drives on the falling edge; released bus lines show inverted values.
`timescale 1ns/1ps
module spl_host_model
  import spl_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Read answer from the block.
  input wire logic [7:0] rdata_reg,
  input wire logic rvalid_reg,
  // Requests and pin towards the block.
  output spl_reg_req_t req,
  output logic slave_select_pin
);
  // The pin idles high, as the pull-up leaves it.
  initial begin
    req = '0;
    slave_select_pin = 1'b1;
  end

  // One write, held for exactly one sampling edge.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk);
    req.wr = 1'b0;
    // Inverted leftovers keep stale values from passing for live ones.
    req.addr = ~a;
    req.wdata = ~d;
  endtask

  // One read; the answer stands only in the cycle after the sampling edge, so it is
  // taken at the falling edge inside that cycle, before the request is dropped.
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    d = rdata_reg;
    v = rvalid_reg;
    req.rd = 1'b0;
    req.addr = ~a;
  endtask

  // Falling toggles of the pin, each low level held four cycles, each high level at least four.
  task automatic toggle(input int n);
    repeat (n) begin
      @(negedge clk);
      slave_select_pin = 1'b0;
      repeat (4) @(negedge clk);
      slave_select_pin = 1'b1;
      repeat (4) @(negedge clk);
    end
  endtask
endmodule

// ===== test/tb_spl_config.sv
// Purpose: Self-checking bench for the port lock and configuration registers.
// Assumes: The line period is shortened to ten cycles to keep the run short.
// Notes: Inputs change on the falling edge; outputs are sampled there too.
`timescale 1ns/1ps
module tb_spl_config
  import spl_pkg::*;
;
  localparam int LP = 10;
  localparam logic [23:0] FS = 24'hff_ffff;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] power_modes = 2'h0;
  logic [1:0] harmonic_timebase_phase_sel = 2'h0;
  spl_reg_req_t req;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic slave_select_pin;
  spl_port_t port_reg;
  logic port_locked_reg;
  spl_phase_t timebase_phase_reg;
  logic [23:0] lp_threshold_reg;
  logic lp_period_tick_reg;
  logic external_reference_select_reg;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;

  // Clock of 100 MHz.
  always #5 clk = ~clk;

  spl_config #(.LINE_PERIOD_CYCLES(LP)) u_dut (
    .clk(clk), .rst_n(rst_n), .req(req), .rdata_reg(rdata_reg), .rvalid_reg(rvalid_reg),
    .slave_select_pin(slave_select_pin), .power_modes(power_modes), .port_reg(port_reg),
    .port_locked_reg(port_locked_reg),
    .harmonic_timebase_phase_sel(harmonic_timebase_phase_sel),
    .timebase_phase_reg(timebase_phase_reg), .lp_threshold_reg(lp_threshold_reg),
    .lp_period_tick_reg(lp_period_tick_reg),
    .external_reference_select_reg(external_reference_select_reg));

  spl_host_model u_host (.clk(clk), .rdata_reg(rdata_reg), .rvalid_reg(rvalid_reg),
    .req(req), .slave_select_pin(slave_select_pin));

  // Counts every comparison and prints each mismatch; case inequality lets no unknown pass.
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Expected threshold, full scale times the field over eight, rounded down.
  function automatic logic [23:0] thr(input logic [2:0] t);
    logic [47:0] p;
    p = FS * t;
    return p[26:3];
  endfunction

  // Reads one register and checks both the strobe and the data.
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    u_host.rd(a, d, v);
    chk("rvalid", 1, v);
    chk("rdata", e, d);
    // The answer stands one cycle only; a cycle later both fall back to zero.
    @(negedge clk);
    chk("rvalid drop", 0, rvalid_reg);
    chk("rdata drop", 8'h00, rdata_reg);
  endtask

  // Holds reset for six cycles; also used in mid-run.
  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
  endtask

  task automatic t_reset();
    rdc(16'hec00, 8'h07);
    rdc(16'hec01, 8'h00);
    chk("threshold reset", thr(3'h7), lp_threshold_reg);
    chk("ext ref reset", 0, external_reference_select_reg);
    chk("port reset", SPL_PORT_I2C, port_reg);
  endtask

  // Every time base code, the reserved one included.
  task automatic t_phase();
    spl_phase_t exp_ph [4] = '{SPL_PH_A, SPL_PH_B, SPL_PH_C, SPL_PH_C};
    for (int c = 0; c < 4; c++) begin
      harmonic_timebase_phase_sel = c[1:0];
      repeat (2) @(negedge clk);
      chk("timebase", exp_ph[c], timebase_phase_reg);
    end
  endtask

  // Every threshold code, then the period of the tick with line count 2.
  task automatic t_level();
    int n;
    for (int t = 0; t < 8; t++) begin
      u_host.wr(16'hec00, {5'h02, t[2:0]});
      @(negedge clk);
      chk("threshold", thr(t[2:0]), lp_threshold_reg);
    end
    rdc(16'hec00, 8'h17);
    n = 0;
    while (lp_period_tick_reg !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (lp_period_tick_reg !== 1'b1 && n < 200);
    chk("tick period", 3 * LP, n);
  endtask

  // Reference select both ways, reserved bits and an unmapped read.
  task automatic t_ref();
    u_host.wr(16'hec01, 8'h01);
    @(negedge clk);
    chk("ext ref on", 1, external_reference_select_reg);
    rdc(16'hec01, 8'h01);
    u_host.wr(16'hec01, 8'hfc);
    @(negedge clk);
    chk("ext ref off", 0, external_reference_select_reg);
    chk("no lock on bit 0", 0, port_locked_reg);
    rdc(16'hec01, 8'h00);
    rdc(16'h1234, 8'h00);
  endtask

  // Two toggles are not enough, the third selects SPI; any write then locks.
  task automatic t_spi();
    u_host.toggle(2);
    chk("port after two", SPL_PORT_I2C, port_reg);
    u_host.toggle(1);
    chk("port after three", SPL_PORT_SPI, port_reg);
    u_host.wr(16'hec01, 8'h00);
    @(negedge clk);
    chk("spi lock", 1, port_locked_reg);
    for (int m = 0; m < 4; m++) begin
      power_modes = m[1:0];
      repeat (3) @(negedge clk);
      chk("spi over modes", SPL_PORT_SPI, port_reg);
    end
    u_host.toggle(3);
    chk("spi kept", SPL_PORT_SPI, port_reg);
    rdc(16'hec01, 8'h02);
  endtask

  // Lock on I2C after two toggles; later toggles and clears change nothing.
  task automatic t_i2c();
    chk("reset unlocks", 0, port_locked_reg);
    chk("reset to i2c", SPL_PORT_I2C, port_reg);
    u_host.toggle(2);
    u_host.wr(16'hec01, 8'h02);
    @(negedge clk);
    chk("i2c lock", 1, port_locked_reg);
    u_host.wr(16'hec01, 8'h00);
    power_modes = 2'h2;
    u_host.toggle(4);
    chk("i2c kept", SPL_PORT_I2C, port_reg);
    chk("lock kept", 1, port_locked_reg);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the few hundred cycles the run needs.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    do_reset();
    t_reset();
    t_phase();
    t_level();
    t_ref();
    t_spi();
    do_reset();
    t_i2c();
    close_out();
  end
endmodule
